// ===== inc/alc_regs.svh
`ifndef ALC_REGS_SVH
`define ALC_REGS_SVH
// ----------------------------------------
// register select codes, control word bits 10:9
// ----------------------------------------
`define ALC_SEL_PRIMARY 2'h0
`define ALC_SEL_FORMAT  2'h1
`define ALC_SEL_RATE    2'h2
`define ALC_SEL_LOOP    2'h3
// ----------------------------------------
// control word fields and bit positions
// ----------------------------------------
`define ALC_CW_SEL_LO   4'h9
`define ALC_CW_DAT_LO   4'hB
`define ALC_PRI_PAR_ODD 2'h1
`define ALC_PRI_RX_EN   2'h2
`define ALC_FAST_CODE   4'hF
`define ALC_REG_RST     4'h0
// ----------------------------------------
// timing, in ns, in cycles of clk and in baud
// ----------------------------------------
`define ALC_CLK_NS      32'h0000_0064
`define ALC_STB_NS      32'h0000_0190
`define ALC_STB_CYC     ((`ALC_STB_NS + `ALC_CLK_NS - 32'h0000_0001) / `ALC_CLK_NS)
`define ALC_CLRM_NS     32'h0000_004B
`define ALC_CLRM_CYC    ((`ALC_CLRM_NS + `ALC_CLK_NS - 32'h0000_0001) / `ALC_CLK_NS)
`define ALC_CAP_GAP     2'h2
`define ALC_FAST_BAUD   32'h0000_9600
`endif

// ===== inc/alc_pkg.sv
package alc_pkg;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       ovr;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } alc_uart_rx_t;

  typedef struct packed {
    logic [1:0] err;
    logic [7:0] data;
  } alc_rx_entry_t;

  typedef struct packed {
    logic [1:0]    line;
    alc_rx_entry_t entry;
  } alc_rx_word_t;

  typedef struct packed {
    logic [1:0] dataLen;
    logic       twoStop;
    logic       parityEn;
    logic       parityOdd;
  } alc_fmt_t;

  // ----------------------------------------
  // state of the line card, apart from the receive fifo
  // ----------------------------------------
  typedef struct packed {
    logic [3:0][3:0]        primary;
    logic [3:0]             loop;
    logic [3:0][3:0]        fmt;
    logic [3:0][3:0]        rate;
    logic [3:0]             speed;
    logic [3:0]             match;
    logic [3:0]             active;
    logic [3:0]             rxFlag;
    logic [3:0]             rxEnPrev;
    alc_rx_entry_t [3:0]    file;
    logic                   stbPrev;
    logic [2:0]             stbCnt;
    logic [1:0]             stbLine;
    logic [1:0]             stbSel;
    logic [1:0]             clrCnt;
    logic [1:0]             clrLine;
    logic                   clrIsMatch;
    logic [3:0][17:0]       divCnt;
    logic [17:0]            xtalCnt;
    logic [1:0]             capGap;
    alc_fmt_t [3:0]         fmtDec;
    logic [3:0]             fmtStb;
    logic [3:0]             rateStb;
    logic [3:0]             clkTick;
    logic [3:0]             txLoad;
    logic [3:0]             uartRd;
    logic [3:0]             clrMatchP;
    logic [3:0]             clrRxP;
    logic [7:0]             txData;
    logic                   txWaitN;
    logic                   rxFlagN;
    logic                   matchN;
    logic                   flagOeN;
    alc_rx_entry_t          rxWord;
    logic                   rxOeN;
  } alc_state_t;
endpackage

// ===== verilog/alc_line_card.sv
`timescale 1ns/10ps
`include "alc_regs.svh"
// Operation
// - format gives 5-8 bits, stops, parity
// - writes only when select bits match card
// - control bits 10:9 pick target register
// - control strobe stretched to 400 ns
// - strobe reaches one of sixteen registers
// - primary stores control bits 11-14
// - loopback bit loads control bit 11
// - format and rate registers four bits
// - init clears primary and loopback only
// - scanner bits 3:2 select card, 1:0 line
// - transmit/receive bit picks flag side
// - transmit waiting low when holding empty
// - receiver flag low on receive or match
// - receiver enable sets match flip-flop
// - data enable clears match or flag
// - generator clock for 50 to 9600 baud
// - rate code 17 octal selects 38.4K
// - speed flip-flop switches clock path
// - receive entry holds data and error
// - three error inputs per character
// - errors priority encoded into two bits
// - flag sets on load, clears on read
// - resync clears active and match

// ----------------------------------------
// receive buffer fifo
// ----------------------------------------
module alc_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } alc_fifo_state_t;

  alc_fifo_state_t r;
  alc_fifo_state_t s;
  logic            push;
  logic            pop;

  // full and empty straight from the count
  assign inReady  = (r.cnt != (AW+1)'(D));
  assign outValid = (r.cnt != '0);
  assign outData  = r.mem[r.rp];

  // pointer wrap is explicit so depths other than powers of two work
  always_comb
  begin
    s    = r;
    push = inValid & inReady;
    pop  = outValid & outReady;
    if (push)
    begin
      s.mem[r.wp] = inData;
      s.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop)
    begin
      s.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
    end
    s.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= s;
    end
  end
endmodule // alc_fifo

// ----------------------------------------
// four-line asynchronous line card control
// ----------------------------------------
module alc_line_card #(
  parameter int unsigned CLK_HZ   = 32'h0098_9680,
  parameter int          RX_DEPTH = 8
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        init,
  input  wire logic [1:0]                  cardPos,
  input  wire logic [3:0]                  lineSelBits,
  input  wire logic [15:0]                 lineCtrlWord,
  input  wire logic                        ctrlStrobe,
  input  wire logic [3:0]                  scanBits,
  input  wire logic                        scanTx,
  input  wire logic                        txStrobe,
  input  wire logic [7:0]                  txChar,
  input  wire logic                        rxDataEnablePulse,
  input  wire logic                        rxFileRead,
  input  wire logic                        resyncPulse,
  input  wire logic [3:0]                  txHoldEmpty,
  input  wire logic [3:0]                  rxAvail,
  input  wire alc_pkg::alc_uart_rx_t [3:0] uartRx,
  output logic [3:0][3:0]                  linePrimary,
  output logic [3:0]                       lineLoopback,
  output alc_pkg::alc_fmt_t [3:0]          lineFormat,
  output logic [3:0][3:0]                  lineRate,
  output logic [3:0]                       fmtStrobe,
  output logic [3:0]                       rateGenStrobe,
  output logic [3:0]                       lineClkTick,
  output logic [3:0]                       txLoad,
  output logic [7:0]                       txData,
  output logic [3:0]                       uartRxRead,
  output logic [3:0]                       clearMatchPulse,
  output logic [3:0]                       clearRxFlagPulse,
  output logic                             txFlagWaitN,
  output logic                             rxFlagN,
  output logic                             matchDetN,
  output logic                             flagOeN,
  output alc_pkg::alc_rx_entry_t           rxFileWord,
  output logic                             rxFileOeN
);
  // doubled baud per rate code so 134.5 stays an integer; code F unused
  localparam int unsigned BAUD_X2 [16] = '{
    32'h0000_0064, 32'h0000_0096, 32'h0000_00DC, 32'h0000_010D,
    32'h0000_012C, 32'h0000_0258, 32'h0000_04B0, 32'h0000_0960,
    32'h0000_0E10, 32'h0000_0FA0, 32'h0000_12C0, 32'h0000_1C20,
    32'h0000_2580, 32'h0000_3840, 32'h0000_4B00, 32'h0001_2C00};
  localparam int unsigned XTAL_DIV = CLK_HZ / `ALC_FAST_BAUD;

  alc_pkg::alc_state_t    r;
  alc_pkg::alc_state_t    s;
  logic [17:0]            divTab [16];
  logic [15:0]            regHit;
  logic [3:0]             cwData;
  logic [1:0]             scanLine;
  logic                   scanHit;
  logic                   stbEdge;
  logic                   xtTick;
  logic                   genTick;
  logic                   anyAvail;
  logic [1:0]             pick;
  logic [3:0]             rxSet;
  logic [3:0]             rxClr;
  logic                   fifoInValid;
  logic                   fifoInReady;
  alc_pkg::alc_rx_word_t  fifoInWord;
  logic                   fifoOutValid;
  logic                   fifoOutReady;
  alc_pkg::alc_rx_word_t  fifoOutWord;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] alcOneHot4(input logic [1:0] l);
    alcOneHot4 = 4'h1 << l;
  endfunction

  function automatic logic [15:0] alcDec16(input logic [3:0] idx);
    alcDec16 = 16'h0001 << idx;
  endfunction

  // overrun over framing over parity
  function automatic logic [1:0] alcErr(input alc_pkg::alc_uart_rx_t u);
    if (u.ovr)
      alcErr = 2'h2;
    else if (u.frm)
      alcErr = 2'h3;
    else if (u.par)
      alcErr = 2'h1;
    else
      alcErr = 2'h0;
  endfunction

  // divider table fixed at elaboration, no runtime divide
  generate
    for (genvar k = 0; k < 16; k++)
    begin : g_div
      localparam int unsigned DV = (2 * CLK_HZ) / BAUD_X2[k];
      assign divTab[k] = 18'(DV);
    end
  endgenerate

  // ----------------------------------------
  // receive buffer between the uarts and the receive file
  // ----------------------------------------
  alc_fifo #(
    .W (12),
    .D (RX_DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inData   (fifoInWord),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutWord),
    .outReady (fifoOutReady)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s            = r;
    s.fmtStb     = '0;
    s.rateStb    = '0;
    s.clkTick    = '0;
    s.txLoad     = '0;
    s.uartRd     = '0;
    s.clrMatchP  = '0;
    s.clrRxP     = '0;
    s.rxOeN      = 1'b1;
    rxSet        = '0;
    rxClr        = '0;
    genTick      = 1'b0;
    anyAvail     = 1'b0;
    pick         = 2'h0;
    fifoInValid  = 1'b0;
    fifoInWord   = '0;
    fifoOutReady = 1'b0;
    regHit       = '0;
    cwData       = lineCtrlWord[`ALC_CW_DAT_LO +: 4];
    scanLine     = scanBits[1:0];
    scanHit      = (scanBits[3:2] == cardPos);
    stbEdge      = ctrlStrobe & ~r.stbPrev;
    s.stbPrev    = ctrlStrobe;

    // control strobe: register write and stretched delivery
    if (r.stbCnt != 3'h0)
      s.stbCnt = r.stbCnt - 3'h1;
    if (stbEdge && (lineSelBits[3:2] == cardPos))
    begin
      regHit    = alcDec16({lineSelBits[1:0], lineCtrlWord[`ALC_CW_SEL_LO +: 2]});
      s.stbCnt  = 3'(`ALC_STB_CYC);
      s.stbLine = lineSelBits[1:0];
      s.stbSel  = lineCtrlWord[`ALC_CW_SEL_LO +: 2];
    end
    for (int i = 0; i < 4; i++)
    begin
      if (regHit[i*4 + `ALC_SEL_PRIMARY])
        s.primary[i] = cwData;
      if (regHit[i*4 + `ALC_SEL_FORMAT])
        s.fmt[i] = cwData;
      if (regHit[i*4 + `ALC_SEL_RATE])
      begin
        s.rate[i]  = cwData;
        s.speed[i] = (cwData == `ALC_FAST_CODE);
      end
      if (regHit[i*4 + `ALC_SEL_LOOP])
        s.loop[i] = cwData[0];
      if (init)
      begin
        s.primary[i] = `ALC_REG_RST;
        s.loop[i]    = 1'b0;
      end
      // strobe width follows the stretch counter, not the input pulse
      s.fmtStb[i]  = (s.stbCnt != 3'h0) && (s.stbLine == 2'(i)) &&
                     (s.stbSel == `ALC_SEL_FORMAT);
      s.rateStb[i] = (s.stbCnt != 3'h0) && (s.stbLine == 2'(i)) &&
                     (s.stbSel == `ALC_SEL_RATE);
      s.fmtDec[i]  = '{dataLen:   r.fmt[i][1:0],
                       twoStop:   r.fmt[i][2],
                       parityEn:  r.fmt[i][3],
                       parityOdd: r.primary[i][`ALC_PRI_PAR_ODD]};
    end

    // data enable: clear match when set, else clear the receive flag
    if (r.clrCnt != 2'h0)
      s.clrCnt = r.clrCnt - 2'h1;
    if (rxDataEnablePulse && scanHit)
    begin
      s.clrCnt     = 2'(`ALC_CLRM_CYC);
      s.clrLine    = scanLine;
      s.clrIsMatch = r.match[scanLine];
      if (r.match[scanLine])
        s.match[scanLine] = 1'b0;
      else
        rxClr[scanLine] = 1'b1;
    end

    // capture one uart character; gap lets data available drop
    if (r.capGap != 2'h0)
      s.capGap = r.capGap - 2'h1;
    else if (fifoInReady)
    begin
      for (int i = 3; i >= 0; i--)
      begin
        if (rxAvail[i])
        begin
          anyAvail = 1'b1;
          pick     = 2'(i);
        end
      end
      if (anyAvail)
      begin
        fifoInValid            = 1'b1;
        fifoInWord.line        = pick;
        fifoInWord.entry.data  = uartRx[pick].data;
        fifoInWord.entry.err   = alcErr(uartRx[pick]);
        s.uartRd               = alcOneHot4(pick);
        s.capGap               = `ALC_CAP_GAP;
      end
    end

    // drain into the file only while that line's entry is free
    if (fifoOutValid && !r.rxFlag[fifoOutWord.line])
    begin
      fifoOutReady                 = 1'b1;
      s.file[fifoOutWord.line]     = fifoOutWord.entry;
      rxSet[fifoOutWord.line]      = 1'b1;
    end

    // microprocessor reads the scanned line's entry
    if (rxFileRead && scanHit && !scanTx)
    begin
      s.rxWord        = r.file[scanLine];
      s.rxOeN         = 1'b0;
      rxClr[scanLine] = 1'b1;
    end

    // transmit load pulse for the scanned line
    if (txStrobe && scanHit && scanTx)
    begin
      s.txLoad = alcOneHot4(scanLine);
      s.txData = txChar;
    end

    // crystal path shared by all four lines
    xtTick = (r.xtalCnt >= 18'(XTAL_DIV - 1));
    s.xtalCnt = xtTick ? 18'h0_0000 : r.xtalCnt + 18'h0_0001;

    for (int i = 0; i < 4; i++)
    begin
      // match and active; a fresh enable edge beats a resync
      if (resyncPulse && scanHit && (scanLine == 2'(i)))
      begin
        s.match[i]  = 1'b0;
        s.active[i] = 1'b0;
      end
      if (s.primary[i][`ALC_PRI_RX_EN] && !r.rxEnPrev[i])
        s.match[i] = 1'b1;
      if (s.match[i])
        s.active[i] = 1'b1;
      // enable low holds both cleared
      if (!s.primary[i][`ALC_PRI_RX_EN])
      begin
        s.match[i]  = 1'b0;
        s.active[i] = 1'b0;
      end
      s.rxEnPrev[i] = s.primary[i][`ALC_PRI_RX_EN];

      // set beats clear; an inactive line cannot flag at all
      s.rxFlag[i] = rxSet[i] | (r.rxFlag[i] & ~rxClr[i]);
      if (!s.active[i])
        s.rxFlag[i] = 1'b0;

      s.clrMatchP[i] = (s.clrCnt != 2'h0) && (s.clrLine == 2'(i)) && s.clrIsMatch;
      s.clrRxP[i]    = (s.clrCnt != 2'h0) && (s.clrLine == 2'(i)) && !s.clrIsMatch;

      // generator path restarts on each rate write
      if (s.rateStb[i])
        s.divCnt[i] = 18'h0_0000;
      else if (r.divCnt[i] >= divTab[r.rate[i]] - 18'h0_0001)
      begin
        s.divCnt[i] = 18'h0_0000;
        genTick     = 1'b1;
      end
      else
        s.divCnt[i] = r.divCnt[i] + 18'h0_0001;
      s.clkTick[i] = r.speed[i] ? xtTick : genTick;
      genTick      = 1'b0;
    end

    // flag lines, released when the card is not scanned
    s.flagOeN = ~scanHit;
    s.txWaitN = ~(scanHit & scanTx & txHoldEmpty[scanLine]);
    s.rxFlagN = ~(scanHit & ~scanTx &
                  (r.rxFlag[scanLine] | r.match[scanLine]));
    s.matchN  = ~(scanHit & ~scanTx & r.match[scanLine]);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r         <= '0;
      r.txWaitN <= 1'b1;
      r.rxFlagN <= 1'b1;
      r.matchN  <= 1'b1;
      r.flagOeN <= 1'b1;
      r.rxOeN   <= 1'b1;
    end
    else
    begin
      r <= s;
    end
  end

  // outputs straight from the state register
  assign linePrimary      = r.primary;
  assign lineLoopback     = r.loop;
  assign lineFormat       = r.fmtDec;
  assign lineRate         = r.rate;
  assign fmtStrobe        = r.fmtStb;
  assign rateGenStrobe    = r.rateStb;
  assign lineClkTick      = r.clkTick;
  assign txLoad           = r.txLoad;
  assign txData           = r.txData;
  assign uartRxRead       = r.uartRd;
  assign clearMatchPulse  = r.clrMatchP;
  assign clearRxFlagPulse = r.clrRxP;
  assign txFlagWaitN      = r.txWaitN;
  assign rxFlagN          = r.rxFlagN;
  assign matchDetN        = r.matchN;
  assign flagOeN          = r.flagOeN;
  assign rxFileWord       = r.rxWord;
  assign rxFileOeN        = r.rxOeN;
endmodule // alc_line_card

// ===== verif/alc_uart_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// uart side of the four lines
// ----------------------------------------
module alc_uart_model (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   post,
  input  wire logic [1:0]             postLine,
  input  wire alc_pkg::alc_uart_rx_t  postChar,
  input  wire logic [3:0]             uartRxRead,
  input  wire logic [3:0]             txLoad,
  output logic [3:0]                  rxAvail,
  output alc_pkg::alc_uart_rx_t [3:0] uartRx,
  output logic [3:0]                  txHoldEmpty
);
  alc_pkg::alc_uart_rx_t [3:0] held_r;

  // a character stays offered until acked, errors ride with it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxAvail <= 4'h0;
      held_r <= '0;
      txHoldEmpty <= 4'hF;
    end
    else
    begin
      rxAvail <= (rxAvail & ~uartRxRead) | ({3'h0, post} << postLine);
      if (post)
        held_r[postLine] <= postChar;
      // holding register is busy only for the cycle after a load
      txHoldEmpty <= ~txLoad;
    end
  end

  // nothing offered: show the inverse so stale data cannot match
  always_comb
    for (int i = 0; i < 4; i++)
      uartRx[i] = rxAvail[i] ? held_r[i] : ~held_r[i];
endmodule // alc_uart_model

// ===== verif/alc_line_card_checker.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checks of the line card
// ----------------------------------------
module alc_line_card_checker (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            init,
  input wire logic [1:0]      cardPos,
  input wire logic [3:0]      lineSelBits,
  input wire logic [15:0]     lineCtrlWord,
  input wire logic            ctrlStrobe,
  input wire logic [3:0]      scanBits,
  input wire logic            scanTx,
  input wire logic            txStrobe,
  input wire logic [7:0]      txChar,
  input wire logic            rxDataEnablePulse,
  input wire logic [3:0]      txHoldEmpty,
  input wire logic [3:0][3:0] linePrimary,
  input wire logic [3:0]      lineLoopback,
  input wire logic [3:0]      fmtStrobe,
  input wire logic [3:0]      rateGenStrobe,
  input wire logic [3:0]      txLoad,
  input wire logic [7:0]      txData,
  input wire logic [3:0]      clearMatchPulse,
  input wire logic [3:0]      clearRxFlagPulse,
  input wire logic            txFlagWaitN,
  input wire logic            flagOeN
);
  logic hit;
  logic wrHit;
  logic stb;

  // scan hit, write hit and any stretched strobe
  assign hit = scanBits[3:2] == cardPos;
  assign wrHit = lineSelBits[3:2] == cardPos && !init;
  assign stb = |{fmtStrobe, rateGenStrobe};

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  card_ignore_a: assert property (
    $rose(ctrlStrobe) && lineSelBits[3:2] != cardPos && !init && !stb
    |=> !stb && $stable(linePrimary) && $stable(lineLoopback))
    else $error("write to another card took effect");
  strobe_width_a: assert property ($rose(stb) |-> stb[*4] ##1 !stb)
    else $error("stretched strobe not four cycles");
  strobe_onehot_a: assert property ($onehot0({fmtStrobe, rateGenStrobe}))
    else $error("strobe reached more than one register");
  primary_load_a: assert property (
    $rose(ctrlStrobe) && wrHit && lineCtrlWord[10:9] == 2'h0
    |=> linePrimary[$past(lineSelBits[1:0])] == $past(lineCtrlWord[14:11]))
    else $error("primary did not take the data bits");
  loop_load_a: assert property (
    $rose(ctrlStrobe) && wrHit && lineCtrlWord[10:9] == 2'h3
    |=> lineLoopback[$past(lineSelBits[1:0])] == $past(lineCtrlWord[11]))
    else $error("loopback bit did not load");
  init_clear_a: assert property (init |=> linePrimary == '0 && lineLoopback == '0)
    else $error("init left primary or loopback set");
  flag_enable_a: assert property (1'b1 |=> flagOeN == $past(!hit))
    else $error("flag enable does not follow card scan");
  tx_wait_a: assert property (
    1'b1 |=> txFlagWaitN == $past(!(hit && scanTx && txHoldEmpty[scanBits[1:0]])))
    else $error("transmit waiting flag wrong");
  tx_load_a: assert property (
    txStrobe && scanTx && hit
    |=> txLoad == 4'h1 << $past(scanBits[1:0]) && txData == $past(txChar))
    else $error("transmit load pulse wrong");
  clear_pulse_a: assert property (
    rxDataEnablePulse && hit
    |=> (clearMatchPulse | clearRxFlagPulse) == 4'h1 << $past(scanBits[1:0]))
    else $error("data enable clear pulse wrong");
endmodule // alc_line_card_checker

bind alc_line_card alc_line_card_checker i_alc_line_card_checker (.*);

// ===== verif/alc_line_card_bench.sv
`timescale 1ns/10ps
module alc_line_card_bench;
  // ----------------------------------------
  // signals, design and uart model
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]  ls;
    logic [15:0] cw;
    logic [4:0]  ex;
  } alc_row_t;
  logic                        clk, rst, init, ctrlStrobe, scanTx, txStrobe, post;
  logic                        rxDataEnablePulse, rxFileRead, resyncPulse;
  logic                        txFlagWaitN, rxFlagN, matchDetN, flagOeN, rxFileOeN;
  logic [1:0]                  cardPos, postLine;
  logic [3:0]                  lineSelBits, scanBits, txHoldEmpty, rxAvail, lineLoopback;
  logic [3:0]                  fmtStrobe, rateGenStrobe, lineClkTick, txLoad, uartRxRead;
  logic [3:0]                  clearMatchPulse, clearRxFlagPulse;
  logic [7:0]                  txChar, txData;
  logic [15:0]                 lineCtrlWord;
  logic [3:0][3:0]             linePrimary, lineRate;
  alc_pkg::alc_uart_rx_t       postChar;
  alc_pkg::alc_uart_rx_t [3:0] uartRx;
  alc_pkg::alc_fmt_t [3:0]     lineFormat;
  alc_pkg::alc_rx_entry_t      rxFileWord;
  int                          bad_count, cmp_count, n;
  // card sits at position 1, lines 4-7
  localparam alc_row_t ROWS [8] = '{
    '{4'h4, 16'h5000, 5'h0A}, '{4'h5, 16'h3A00, 5'h1C}, '{4'h4, 16'h0200, 5'h01},
    '{4'h6, 16'h7400, 5'h0E}, '{4'h5, 16'h7C00, 5'h0F}, '{4'h7, 16'h0E00, 5'h01},
    '{4'h7, 16'h0600, 5'h00}, '{4'hC, 16'h2800, 5'h0A}};
  // {ovr, frm, par, expected field}
  localparam logic [4:0] ERRS [6] = '{5'h00, 5'h05, 5'h0B, 5'h0F, 5'h12, 5'h1E};

  alc_line_card i_alc_line_card (.*);
  alc_uart_model i_alc_uart_model (.*);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] g);
    cmp_count++;
    if (g !== ex)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // 300 ns strobe, then room for the stretch to end
  task automatic wr(logic [3:0] ls, logic [15:0] cw);
    lineSelBits = ls;
    lineCtrlWord = cw;
    ctrlStrobe = 1'b1;
    cyc(3);
    ctrlStrobe = 1'b0;
    cyc(4);
  endtask
  function automatic logic sig(int k, logic [1:0] l);
    case (k)
      0: return uartRxRead[l];
      1: return !rxFlagN;
      default: return lineClkTick[l];
    endcase
  endfunction
  // bounded wait; a hang ends the run only when hang is set
  task automatic waitSig(int k, logic [1:0] l, int lim, bit hang);
    n = 0;
    while (sig(k, l) !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= lim && hang)
    begin
      bad_count++;
      $display("ERROR wait %0d expected 1 seen 0", k);
      summarize;
    end
  endtask
  function automatic logic [15:0] got(alc_row_t r);
    case (r.cw[10:9])
      2'h0: return 16'(linePrimary[r.ls[1:0]]);
      2'h1: return 16'(lineFormat[r.ls[1:0]]);
      2'h2: return 16'(lineRate[r.ls[1:0]]);
      default: return 16'(lineLoopback[r.ls[1:0]]);
    endcase
  endfunction
  task automatic period(logic [1:0] l, int lim, logic [15:0] ex);
    waitSig(2, l, lim, 1'b1);
    cyc(1);
    waitSig(2, l, lim, 1'b1);
    chk("tick period", ex, 16'(n + 1));
  endtask
  task automatic enRx;
    wr(4'h4, 16'h0000);
    wr(4'h4, 16'h2000);
  endtask
  task automatic postc(logic [10:0] ch);
    postChar = ch;
    pulse(post);
    waitSig(0, 2'h0, 20, 1'b0);
  endtask
  task automatic rd(logic [9:0] ex);
    waitSig(1, 2'h0, 40, 1'b1);
    pulse(rxFileRead);
    chk("rxFile", {6'h00, ex}, {5'h00, rxFileOeN, rxFileWord});
    cyc(2);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {init, ctrlStrobe, scanTx, txStrobe, post, rxDataEnablePulse, rxFileRead} = '0;
    {resyncPulse, postLine, lineSelBits, scanBits, txChar, lineCtrlWord, postChar} = '0;
    {bad_count, cmp_count} = '0;
    cardPos = 2'h1;
    rst = 1'b1;
    cyc(10);
    rst = 1'b0;
    cyc(1);
    chk("reset", 16'h000F, {linePrimary[3:1], flagOeN, txFlagWaitN, rxFlagN, matchDetN});
    $display("reset test done");
    foreach (ROWS[i])
    begin
      wr(ROWS[i].ls, ROWS[i].cw);
      chk("register", 16'(ROWS[i].ex), got(ROWS[i]));
    end
    $display("register rows done");
    wr(4'h7, 16'h0E00);
    pulse(init);
    chk("init", 16'h0000, linePrimary | 16'(lineLoopback));
    chk("rate kept", 16'h0EF0, lineRate);
    period(2'h2, 1100, 16'h0411);
    period(2'h1, 300, 16'h0104);
    $display("init and rate test done");
    scanBits = 4'h6;
    scanTx = 1'b1;
    cyc(2);
    chk("tx flags", 16'h0000, {14'h0, flagOeN, txFlagWaitN});
    txChar = 8'h5A;
    pulse(txStrobe);
    chk("txLoad", 16'h045A, {4'h0, txLoad, txData});
    scanBits = 4'hE;
    cyc(2);
    chk("other card", 16'h000F, {12'h0, flagOeN, txFlagWaitN, rxFlagN, matchDetN});
    $display("flag test done");
    scanBits = 4'h4;
    scanTx = 1'b0;
    enRx;
    chk("match", 16'h0000, {14'h0, matchDetN, rxFlagN});
    pulse(rxDataEnablePulse);
    chk("clear match", 16'h0010, {8'h0, clearMatchPulse, clearRxFlagPulse});
    pulse(rxDataEnablePulse);
    chk("clear flag", 16'h0001, {8'h0, clearMatchPulse, clearRxFlagPulse});
    enRx;
    pulse(resyncPulse);
    cyc(1);
    chk("resync", 16'h0003, {14'h0, matchDetN, rxFlagN});
    enRx;
    pulse(rxDataEnablePulse);
    $display("match test done");
    foreach (ERRS[i])
    begin
      postc({ERRS[i][4:2], 8'hC3});
      chk("accepted", 16'h0001, 16'(n < 20));
      rd({ERRS[i][1:0], 8'hC3});
    end
    $display("error field test done");
    // reader stalls: one in the file, eight queued, then refused
    for (int k = 0; k < 10; k++)
    begin
      postc({3'h0, 8'(k)});
      chk("accepted", 16'(k < 9), 16'(n < 20));
    end
    for (int k = 0; k < 10; k++)
      rd({2'h0, 8'(k)});
    chk("flag clear", 16'h0001, 16'(rxFlagN));
    $display("buffer test done");
    summarize;
  end
endmodule // alc_line_card_bench
